// ---- logic/shsc_regs.svh ----
// Timing counts and encodings for the standby controller
// Assumes inclusion by bare name from the logic folder
`ifndef SHSC_REGS_SVH
`define SHSC_REGS_SVH
`define SHSC_CLK_NS       100
`define SHSC_VEC_WAIT     4'h8
`define SHSC_NXT_WAIT     4'h2
`define SHSC_OST_BASE     2048
`define SHSC_OST_SEL_W    3
`define SHSC_CNT_W        20
`endif

// ---- logic/shsc_pkg.sv ----
// Types for the standby controller
// Assumes nothing beyond a SystemVerilog compiler
package shsc_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_HALT, ST_STOP, ST_OST, ST_WAIT
  } shsc_state_t;
  typedef struct packed {
    logic mask;
    logic prio;
    logic ie;
    logic in_service_priority_flag;
  } shsc_flags_t;
  typedef struct packed {
    logic t50Ext;
    logic t51Ext;
    logic h1Slow;
    logic wdtSwStop;
    logic uartT50;
    logic csiExt;
  } shsc_pcfg_t;
  typedef struct packed {
    logic cpuClk;
    logic fastOsc;
    logic xtalOsc;
    logic extClkIn;
    logic slowOsc;
    logic pll;
    logic flash;
    logic tm00;
    logic usb;
    logic regLowCur;
  } shsc_clk_t;
  typedef struct packed {
    logic t50;
    logic t51;
    logic h1;
    logic wdt;
    logic uart;
    logic csi;
    logic poc;
    logic lvi;
    logic extInt;
    logic hold;
  } shsc_pen_t;
endpackage

// ---- logic/shsc_standby_ctrl.sv ----
// Standby controller: HALT and STOP entry, release and gating
// Assumes CPU pulses haltExec/stopExec for one mclk cycle
`timescale 1ns/100ps
`include "shsc_regs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////
// Operation
// - Unmasked request ends HALT; vector if enabled, else next instruction.
// - Vectored HALT release waits 8 CPU clocks before servicing.
// - Non-vectored HALT release resumes after 2 CPU clocks.
// - Reset ends HALT and restarts from the reset vector.
// - Masked request keeps HALT; reset always wins.
// - Vector needs enable, plus in-service flag when priority select is 1.
// - STOP entered only by instruction while CPU runs on main clock.
// - Pending unmasked request at STOP skips STOP and HALT, resumes after stabilization.
// - STOP cuts CPU clock, fast and crystal oscillators, ignores external clock.
// - STOP keeps slow oscillator state, RAM and port latches.
// - STOP keeps regulators on in low current mode.
// - Timers 50/51 count in STOP only with external count input.
// - Timer H1 counts in STOP only from the slow oscillator clock.
// - Watchdog runs in STOP unless slow oscillator is software stoppable.
// - Async serial unit runs in STOP only on running timer 50 output.
// - Clocked serial unit runs in STOP only with external clock.
// - Unmasked request releases STOP; after stabilization vector or continue.
module shsc_standby_ctrl #(
  parameter int unsigned OST_BASE = `SHSC_OST_BASE
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        haltExec,
  input  wire logic                        stopExec,
  input  wire logic                        cpuOnMain,
  input  wire logic                        intReq,
  input  wire shsc_pkg::shsc_flags_t       flags,
  input  wire logic [`SHSC_OST_SEL_W-1:0]  oscStabSel,
  input  wire logic                        slowOscOn,
  input  wire logic                        t50Running,
  input  wire shsc_pkg::shsc_pcfg_t        pcfg,
  output logic                             vectorStart,
  output logic                             resumeNext,
  output logic                             resetVecStart,
  output logic                             haltMode,
  output logic                             stopMode,
  output shsc_pkg::shsc_clk_t              clkEn,
  output shsc_pkg::shsc_pen_t              perEn
);

  shsc_pkg::shsc_state_t         state_r;
  shsc_pkg::shsc_state_t         state_nxt;
  logic [`SHSC_CNT_W-1:0]        cnt_r;
  logic [`SHSC_CNT_W-1:0]        cnt_nxt;
  logic                          vec_r;
  logic                          vec_nxt;
  logic                          rstSeen_r;
  logic                          wake;
  logic                          wantVec;
  logic                          goStop;

  // Vector decision shared by HALT and STOP release
  function automatic logic vec_ok(input shsc_pkg::shsc_flags_t f);
    vec_ok = f.ie & (~f.prio | f.in_service_priority_flag);
  endfunction

  // Stabilization wait in mclk cycles, doubling per select step
  function automatic logic [`SHSC_CNT_W-1:0] ost_cnt(
    input logic [`SHSC_OST_SEL_W-1:0] sel);
    ost_cnt = `SHSC_CNT_W'(OST_BASE) << sel;
  endfunction

  assign wake    = intReq & ~flags.mask;
  assign wantVec = vec_ok(flags);
  assign goStop  = stopExec & cpuOnMain;

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    vec_nxt   = vec_r;
    case (state_r)
      shsc_pkg::ST_RUN: begin
        if (goStop && wake) begin
          state_nxt = shsc_pkg::ST_OST;
          cnt_nxt   = ost_cnt(oscStabSel) - 1'b1;
        end else if (goStop) begin
          state_nxt = shsc_pkg::ST_STOP;
        end else if (haltExec) begin
          state_nxt = shsc_pkg::ST_HALT;
        end
      end
      shsc_pkg::ST_HALT: begin
        if (wake) begin
          state_nxt = shsc_pkg::ST_WAIT;
          vec_nxt   = wantVec;
          // Count starts at request; one cycle spent here
          cnt_nxt   = wantVec ? `SHSC_CNT_W'(`SHSC_VEC_WAIT - 4'h2) :
                                `SHSC_CNT_W'(`SHSC_NXT_WAIT - 4'h2);
        end
      end
      shsc_pkg::ST_STOP: begin
        if (wake) begin
          state_nxt = shsc_pkg::ST_OST;
          cnt_nxt   = ost_cnt(oscStabSel) - 1'b1;
        end
      end
      shsc_pkg::ST_OST: begin
        if (cnt_r == '0) begin
          state_nxt = shsc_pkg::ST_RUN;
          vec_nxt   = wantVec;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      shsc_pkg::ST_WAIT: begin
        if (cnt_r == '0) begin
          state_nxt = shsc_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = shsc_pkg::ST_RUN;
      end
    endcase
  end

  // Reset returns to run from any mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= shsc_pkg::ST_RUN;
      cnt_r   <= '0;
      vec_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      vec_r   <= vec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Release strobes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vectorStart <= 1'b0;
      resumeNext  <= 1'b0;
    end else begin
      vectorStart <= 1'b0;
      resumeNext  <= 1'b0;
      if (state_r == shsc_pkg::ST_WAIT && cnt_r == '0) begin
        vectorStart <= vec_r;
        resumeNext  <= ~vec_r;
      end
      if (state_r == shsc_pkg::ST_OST && cnt_r == '0) begin
        vectorStart <= wantVec;
        resumeNext  <= ~wantVec;
      end
    end
  end

  // One pulse after release: fetch from reset vector
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSeen_r     <= 1'b0;
      resetVecStart <= 1'b0;
    end else begin
      rstSeen_r     <= 1'b1;
      resetVecStart <= ~rstSeen_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode flags and clock gating
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      haltMode <= 1'b0;
      stopMode <= 1'b0;
    end else begin
      haltMode <= state_nxt == shsc_pkg::ST_HALT ||
                  state_nxt == shsc_pkg::ST_WAIT;
      stopMode <= state_nxt == shsc_pkg::ST_STOP;
    end
  end

  // Gated from next state so outputs align with the mode flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clkEn <= '{cpuClk: 1'b1, fastOsc: 1'b1, xtalOsc: 1'b1,
                 extClkIn: 1'b1, slowOsc: 1'b1, pll: 1'b1,
                 flash: 1'b1, tm00: 1'b1, usb: 1'b1,
                 regLowCur: 1'b0};
    end else begin
      if (state_nxt == shsc_pkg::ST_STOP) begin
        clkEn.cpuClk    <= 1'b0;
        clkEn.fastOsc   <= 1'b0;
        clkEn.xtalOsc   <= 1'b0;
        clkEn.extClkIn  <= 1'b0;
        clkEn.pll       <= 1'b0;
        clkEn.flash     <= 1'b0;
        clkEn.tm00      <= 1'b0;
        clkEn.usb       <= 1'b0;
        clkEn.regLowCur <= 1'b1;
      end else begin
        // Fast and crystal oscillators restart outside STOP, slow one follows slowOscOn; CPU and flash clocks only in run
        clkEn.cpuClk    <= state_nxt == shsc_pkg::ST_RUN;
        clkEn.fastOsc   <= 1'b1;
        clkEn.xtalOsc   <= 1'b1;
        clkEn.extClkIn  <= 1'b1;
        clkEn.pll       <= 1'b1;
        clkEn.flash     <= state_nxt == shsc_pkg::ST_RUN;
        clkEn.tm00      <= 1'b1;
        clkEn.usb       <= 1'b1;
        clkEn.regLowCur <= 1'b0;
      end
      clkEn.slowOsc <= slowOscOn;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Peripheral run enables
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      perEn <= '{t50: 1'b1, t51: 1'b1, h1: 1'b1, wdt: 1'b1,
                 uart: 1'b1, csi: 1'b1, poc: 1'b1, lvi: 1'b1,
                 extInt: 1'b1, hold: 1'b0};
    end else if (state_nxt == shsc_pkg::ST_STOP) begin
      perEn.t50    <= pcfg.t50Ext;
      perEn.t51    <= pcfg.t51Ext;
      perEn.h1     <= pcfg.h1Slow;
      perEn.wdt    <= ~pcfg.wdtSwStop;
      perEn.uart   <= pcfg.uartT50 & t50Running;
      perEn.csi    <= pcfg.csiExt;
      perEn.poc    <= 1'b1;
      perEn.lvi    <= 1'b1;
      perEn.extInt <= 1'b1;
      perEn.hold   <= 1'b1;
    end else begin
      perEn <= '{t50: 1'b1, t51: 1'b1, h1: 1'b1, wdt: 1'b1,
                 uart: 1'b1, csi: 1'b1, poc: 1'b1, lvi: 1'b1,
                 extInt: 1'b1, hold: 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_halt_masked: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && intReq && flags.mask && !haltExec
    |=> state_r == shsc_pkg::ST_HALT)
    else $error("masked request left halt");

  a_halt_vec_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && wake && wantVec
    |-> ##8 vectorStart)
    else $error("vector not issued 8 clocks after request");

  a_halt_nxt_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && wake && !wantVec
    |-> ##2 resumeNext)
    else $error("resume not issued 2 clocks after request");

  a_halt_release: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && wake |=> state_r == shsc_pkg::ST_WAIT)
    else $error("unmasked request did not end halt");

  a_release_leaves_standby: assert property (@(posedge mclk) disable iff (!rst_b)
    vectorStart || resumeNext |-> !haltMode && !stopMode)
    else $error("strobe issued while still in standby");

  a_vec_decide: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && wake && flags.prio && !flags.in_service_priority_flag
    |-> ##2 resumeNext)
    else $error("vector taken without in-service flag");

  a_stop_main: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_RUN && stopExec && !cpuOnMain
    |=> !stopMode)
    else $error("stop entered off main clock");

  a_stop_abort: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_RUN && goStop && wake
    |=> state_r == shsc_pkg::ST_OST && !stopMode)
    else $error("pending request did not abort stop");

  a_stop_clocks: assert property (@(posedge mclk) disable iff (!rst_b)
    stopMode |-> !clkEn.cpuClk && !clkEn.fastOsc && !clkEn.xtalOsc &&
    !clkEn.extClkIn && clkEn.regLowCur)
    else $error("clock still running in stop");

  a_stop_wdt: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_STOP && $stable(pcfg.wdtSwStop)
    && $past(state_r) == shsc_pkg::ST_STOP
    |-> perEn.wdt == !pcfg.wdtSwStop)
    else $error("watchdog gating wrong in stop");

  a_stop_release: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_STOP && wake |=> state_r == shsc_pkg::ST_OST)
    else $error("unmasked request did not leave stop");

  c_halt_vec: cover property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_HALT && wake && wantVec ##8 vectorStart);
  c_stop_wake: cover property (@(posedge mclk) disable iff (!rst_b)
    stopMode ##1 state_r == shsc_pkg::ST_OST);
  c_stop_abort: cover property (@(posedge mclk) disable iff (!rst_b)
    state_r == shsc_pkg::ST_RUN && goStop && wake);

endmodule
`default_nettype wire

// ---- sim/tb_standby_halt_stop_control.sv ----
// Self-checking bench for the standby controller
// Assumes logic/shsc_pkg.sv and logic/shsc_standby_ctrl.sv are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_standby_halt_stop_control;
  localparam int unsigned OST = 4; // Short stabilisation count keeps the run brief
  logic                   mclk;
  logic                   rst_b;
  logic                   haltExec;
  logic                   stopExec;
  logic                   cpuOnMain;
  logic                   intReq;
  shsc_pkg::shsc_flags_t  flags;
  logic [2:0]             oscStabSel;
  logic                   slowOscOn;
  logic                   t50Running;
  shsc_pkg::shsc_pcfg_t   pcfg;
  logic                   vectorStart;
  logic                   resumeNext;
  logic                   resetVecStart;
  logic                   haltMode;
  logic                   stopMode;
  shsc_pkg::shsc_clk_t    clkEn;
  shsc_pkg::shsc_pen_t    perEn;
  int                     fails;
  int                     tests_run;
  shsc_standby_ctrl #(.OST_BASE(OST)) shsc_standby_ctrl_i (
    .mclk(mclk), .rst_b(rst_b), .haltExec(haltExec), .stopExec(stopExec),
    .cpuOnMain(cpuOnMain), .intReq(intReq), .flags(flags), .oscStabSel(oscStabSel),
    .slowOscOn(slowOscOn), .t50Running(t50Running), .pcfg(pcfg),
    .vectorStart(vectorStart), .resumeNext(resumeNext), .resetVecStart(resetVecStart),
    .haltMode(haltMode), .stopMode(stopMode), .clkEn(clkEn), .perEn(perEn));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  function automatic logic expVec(shsc_pkg::shsc_flags_t f);
    return f.ie & (~f.prio | f.in_service_priority_flag);
  endfunction
  // Counts edges from the sampling edge until a strobe shows
  task automatic waitStrobe(output int n, output logic v);
    n = 0;
    v = 1'bx;
    repeat (200) begin
      step();
      n++;
      if (vectorStart === 1'b1 || resumeNext === 1'b1) begin
        v = vectorStart;
        break;
      end
    end
  endtask
  // Masked request must not wake; watches for stray strobes meanwhile
  task automatic holdMasked(shsc_pkg::shsc_flags_t f, output logic seen);
    seen = 1'b0;
    flags = f;
    flags.mask = 1'b1;
    intReq = 1'b1;
    repeat (10) begin
      step();
      if (vectorStart !== 1'b0 || resumeNext !== 1'b0) seen = 1'b1;
    end
    flags.mask = 1'b0;
  endtask
  task automatic doHalt(shsc_pkg::shsc_flags_t f);
    int n;
    logic v;
    logic seen;
    haltExec = 1'b1;
    step();
    haltExec = 1'b0;
    step();
    `CHK({haltMode, clkEn.cpuClk}, 2'b10, "halt entry")
    holdMasked(f, seen);
    `CHK({seen, haltMode}, 2'b01, "masked request woke halt")
    waitStrobe(n, v);
    intReq = 1'b0;
    `CHK(v, expVec(f), "halt vector decision")
    `CHK(n, expVec(f) ? 8 : 2, "halt release wait")
    `CHK(haltMode, 1'b0, "halt not left")
  endtask
  task automatic doStop(shsc_pkg::shsc_flags_t f, logic [2:0] sel, logic pend);
    int n;
    logic v;
    logic seen;
    shsc_pkg::shsc_clk_t ec;
    shsc_pkg::shsc_pen_t ep;
    {slowOscOn, t50Running, pcfg} = 8'($urandom);
    oscStabSel = sel;
    cpuOnMain = 1'b1;
    flags = f;
    flags.mask = 1'b0;
    intReq = pend;
    stopExec = 1'b1;
    step();
    stopExec = 1'b0;
    if (pend) begin
      `CHK(stopMode, 1'b0, "pending request entered stop")
      waitStrobe(n, v);
      n++;
    end else begin
      step();
      ec = '0;
      ec.slowOsc = slowOscOn;
      ec.regLowCur = 1'b1;
      ep = {pcfg.t50Ext, pcfg.t51Ext, pcfg.h1Slow, ~pcfg.wdtSwStop,
            pcfg.uartT50 & t50Running, pcfg.csiExt, 4'hf};
      `CHK(stopMode, 1'b1, "stop entry")
      `CHK(clkEn, ec, "stop clock gating")
      `CHK(perEn, ep, "stop peripheral gating")
      holdMasked(f, seen);
      `CHK({seen, stopMode}, 2'b01, "masked request woke stop")
      waitStrobe(n, v);
    end
    intReq = 1'b0;
    `CHK(v, expVec(f), "stop vector decision")
    `CHK(n, (OST << sel) + 1, "stabilisation wait")
    `CHK({stopMode, perEn.hold, clkEn.cpuClk}, 3'b001, "stop not left")
  endtask
  task automatic resetCheck();
    `CHK({haltMode, stopMode, clkEn, perEn}, 22'h0ffbfe, "reset state")
    rst_b = 1'b1;
    step();
    `CHK(resetVecStart, 1'b1, "reset vector start")
    step();
    `CHK(resetVecStart, 1'b0, "reset vector repeated")
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  initial begin
    {rst_b, haltExec, stopExec, cpuOnMain, intReq, flags} = '0;
    {oscStabSel, slowOscOn, t50Running, pcfg} = '0;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'h7b172881));
    repeat (5) step();
    resetCheck();
    // Every unmasked flag combination
    for (int i = 0; i < 8; i++) doHalt(shsc_pkg::shsc_flags_t'(4'(i)));
    // Stop refused when not on the main clock
    stopExec = 1'b1;
    step();
    stopExec = 1'b0;
    step();
    `CHK(stopMode, 1'b0, "stop taken off main clock")
    // Reset in the middle of a halt
    haltExec = 1'b1;
    step();
    haltExec = 1'b0;
    step();
    rst_b = 1'b0;
    step();
    resetCheck();
    for (int i = 0; i < 24; i++) begin
      if (i % 3 == 0) doHalt(shsc_pkg::shsc_flags_t'(4'($urandom)));
      else doStop(shsc_pkg::shsc_flags_t'(4'($urandom)), 3'($urandom_range(2)),
                  1'(i % 3 == 2));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
